// ===== design/program_status_flags.sv
// Program status flag register with AXI4-Lite access and ALU update port
// Summary of operation
// - Carry (bit 7) takes the ALU carry out on an arithmetic update with upd_carry set.
// - Carry is the one-bit accumulator that bit instructions use.
// - Aux carry (bit 6) takes the nibble carry or borrow of the ALU.
// - User flag zero (bit 5) changes only on a software write.
// - User flag one (bit 1) changes only on a software write.
// - Overflow (bit 2) is the carry out of bit six xor that of bit seven.
// - Parity (bit 0) is high one clock after the accumulator holds odd ones.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module program_status_flags (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [flags_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [flags_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic alu_update,
  input wire logic upd_carry,
  input wire logic upd_aux_carry,
  input wire logic upd_overflow,
  input wire logic alu_carry_out,
  input wire logic alu_carry_bit6,
  input wire logic alu_nibble_carry,
  input wire logic bit_write,
  input wire logic bit_value,
  input wire logic [7:0] accumulator,
  output logic [7:0] status_word,
  output logic carry_flag,
  output logic [7:0] bank_base
);
  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] bank_base;
    logic aw_got;
    logic [flags_pkg::ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic w_lane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  logic acc_odd;
  logic sw_wr;

  // Parity of the accumulator, registered into bit 0 below
  parity_tree #(.WIDTH(8)) u_parity (
    .data(accumulator),
    .odd(acc_odd)
  );

  // ************************************************************
  // Next state
  // ************************************************************
  // Bus slave first, then software write, then hardware updates
  always_comb begin
    st_nxt = st_r;
    sw_wr = 1'h0;
    // Write address and data are taken in either order
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.aw_got = 1'h1;
      st_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.w_got = 1'h1;
      st_nxt.w_data = s_axi_wdata;
      st_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'h0;
    end
    // Both halves held: commit and answer
    if (st_nxt.aw_got && st_nxt.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'h0;
      st_nxt.w_got = 1'h0;
      st_nxt.bvalid = 1'h1;
      if (st_nxt.aw_addr[11:2] == flags_pkg::FLAGS_OFFSET[11:2]) begin
        st_nxt.bresp = flags_pkg::RESP_OKAY;
        sw_wr = st_nxt.w_lane0;
      end else begin
        st_nxt.bresp = flags_pkg::RESP_SLVERR;
      end
    end
    // Software owns bits 7..1; parity is never written by software
    if (sw_wr) begin
      st_nxt.flags[flags_pkg::CARRY_BIT:flags_pkg::USER_FLAG_ONE_BIT] =
        st_nxt.w_data[7:1];
    end
    // Bit instructions use carry as their accumulator
    if (bit_write) begin
      st_nxt.flags[flags_pkg::CARRY_BIT] = bit_value;
    end
    // Arithmetic results override software in the same cycle
    if (alu_update) begin
      if (upd_carry) begin
        st_nxt.flags[flags_pkg::CARRY_BIT] = alu_carry_out;
      end
      if (upd_aux_carry) begin
        st_nxt.flags[flags_pkg::AUX_CARRY_BIT] = alu_nibble_carry;
      end
      if (upd_overflow) begin
        st_nxt.flags[flags_pkg::OVERFLOW_BIT] =
          alu_carry_bit6 ^ alu_carry_out;
      end
    end
    st_nxt.flags[flags_pkg::PARITY_BIT] = acc_odd;
    // Working register base from the bank select pair
    st_nxt.bank_base = {3'h0,
      st_nxt.flags[flags_pkg::BANK_SELECT_HIGH_BIT:
                   flags_pkg::BANK_SELECT_LOW_BIT],
      3'h0};
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready = !st_nxt.w_got && !st_nxt.bvalid;
    // Read channel: one read at a time
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'h0;
    end
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.rvalid = 1'h1;
      if (s_axi_araddr[11:2] == flags_pkg::FLAGS_OFFSET[11:2]) begin
        st_nxt.rdata = {24'h00_0000, st_r.flags};
        st_nxt.rresp = flags_pkg::RESP_OKAY;
      end else begin
        st_nxt.rdata = 32'h0000_0000;
        st_nxt.rresp = flags_pkg::RESP_SLVERR;
      end
    end
    st_nxt.arready = !st_nxt.rvalid;
  end

  // ************************************************************
  // Registers and outputs
  // ************************************************************
  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.flags <= flags_pkg::FLAGS_RESET;
      st_r.bank_base <= flags_pkg::BANK_BASE_RESET;
      st_r.bresp <= flags_pkg::RESP_OKAY;
      st_r.rresp <= flags_pkg::RESP_OKAY;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign s_axi_awready = st_r.awready;
  assign s_axi_wready = st_r.wready;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_arready = st_r.arready;
  assign s_axi_rdata = st_r.rdata;
  assign s_axi_rresp = st_r.rresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign status_word = st_r.flags;
  assign carry_flag = st_r.flags[flags_pkg::CARRY_BIT];
  assign bank_base = st_r.bank_base;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Flag updates from the arithmetic unit, bit instructions, software and accumulator, and the bank base
  carry_update_a: assert property (
    alu_update && upd_carry |=>
    status_word[flags_pkg::CARRY_BIT] == $past(alu_carry_out))
    else $error("carry does not follow alu carry out");
  bit_accum_a: assert property (
    bit_write && !(alu_update && upd_carry) |=>
    carry_flag == $past(bit_value))
    else $error("bit write did not reach carry");
  aux_carry_a: assert property (
    alu_update && upd_aux_carry |=>
    status_word[flags_pkg::AUX_CARRY_BIT] == $past(alu_nibble_carry))
    else $error("aux carry wrong");
  flag_zero_a: assert property (
    !sw_wr |=> $stable(status_word[flags_pkg::USER_FLAG_ZERO_BIT]))
    else $error("user flag zero changed without software");
  flag_one_a: assert property (
    !sw_wr |=> $stable(status_word[flags_pkg::USER_FLAG_ONE_BIT]))
    else $error("user flag one changed without software");
  overflow_a: assert property (
    alu_update && upd_overflow |=>
    status_word[flags_pkg::OVERFLOW_BIT] ==
    ($past(alu_carry_bit6) ^ $past(alu_carry_out)))
    else $error("overflow wrong");
  parity_track_a: assert property (
    $past(aresetn) |->
    status_word[flags_pkg::PARITY_BIT] == ^$past(accumulator))
    else $error("parity does not follow accumulator");
  bank_map_a: assert property (
    bank_base == {3'h0, status_word[4:3], 3'h0})
    else $error("bank base wrong");

  // Bus answers stand until taken, and no new write while one is answered
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before it was taken");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before it was taken");
  write_busy_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while a response is pending");

  // Main scenarios
  wr_seen_c: cover property (sw_wr ##1 s_axi_bvalid);
  rd_seen_c: cover property (s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid);
  overflow_set_c: cover property (alu_update && upd_overflow ##1
    status_word[flags_pkg::OVERFLOW_BIT]);
  top_bank_c: cover property (bank_base == 8'h18);
endmodule
`default_nettype wire

// ===== design/psw_pkg.sv
// Package of offsets, field positions and reset values for the status flags
package flags_pkg;
  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] FLAGS_OFFSET = 12'h0d0; // Byte address of the word
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ************************************************************
  // Field positions inside the status word
  // ************************************************************
  localparam int CARRY_BIT = 7;
  localparam int AUX_CARRY_BIT = 6;
  localparam int USER_FLAG_ZERO_BIT = 5;
  localparam int BANK_SELECT_HIGH_BIT = 4;
  localparam int BANK_SELECT_LOW_BIT = 3;
  localparam int OVERFLOW_BIT = 2;
  localparam int USER_FLAG_ONE_BIT = 1;
  localparam int PARITY_BIT = 0;
  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] BANK_BASE_RESET = 8'h00;
endpackage

// ===== design/parity_tree.sv
// Odd-parity reduction of a data word
`timescale 1ns/10ps
`default_nettype none
module parity_tree #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] data,
  output logic odd
);
  // High when the word holds an odd number of ones
  assign odd = ^data;
endmodule
`default_nettype wire

// ===== verification/alu_sequencer_model.sv
// Model of the arithmetic unit and sequencer that update the flags
`timescale 1ns/10ps
`default_nettype none
module alu_sequencer_model (
  input wire logic aclk,
  output logic alu_update,
  output logic upd_carry,
  output logic upd_aux_carry,
  output logic upd_overflow,
  output logic alu_carry_out,
  output logic alu_carry_bit6,
  output logic alu_nibble_carry,
  output logic bit_write,
  output logic bit_value,
  output logic [7:0] accumulator
);
  // Idle port: no update requested, accumulator empty
  initial begin
    {alu_update, upd_carry, upd_aux_carry, upd_overflow} = 4'h0;
    {alu_carry_out, alu_carry_bit6, alu_nibble_carry} = 3'h0;
    {bit_write, bit_value} = 2'h0;
    accumulator = 8'h00;
  end
  // One arithmetic result; alu_update dropped and enables inverted afterwards
  task automatic arith(input logic [2:0] en, input logic [2:0] cy);
    @(posedge aclk);
    alu_update <= 1'h1;
    {upd_carry, upd_aux_carry, upd_overflow} <= en;
    {alu_carry_out, alu_carry_bit6, alu_nibble_carry} <= cy;
    @(posedge aclk);
    alu_update <= 1'h0;
    {upd_carry, upd_aux_carry, upd_overflow} <= ~en;
  endtask
  // Bit instruction writing the carry
  task automatic bitop(input logic v);
    @(posedge aclk);
    bit_write <= 1'h1;
    bit_value <= v;
    @(posedge aclk);
    bit_write <= 1'h0;
    bit_value <= ~v;
  endtask
  // New accumulator contents
  task automatic load(input logic [7:0] v);
    @(posedge aclk);
    accumulator <= v;
  endtask
endmodule
`default_nettype wire

// ===== verification/program_status_flags_tb.sv
// Self-checking bench for the program status flag register
`timescale 1ns/10ps
`default_nettype none
module program_status_flags_tb;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, carry_flag, alu_update, upd_carry, upd_aux_carry;
  logic upd_overflow, alu_carry_out, alu_carry_bit6, alu_nibble_carry;
  logic bit_write, bit_value;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] status_word, bank_base, accumulator;
  int miscompares = 0, n_compared = 0;
  localparam logic [11:0] REG_ADDR = flags_pkg::FLAGS_OFFSET;
  // Clock and the two instances
  always #12.5 aclk = ~aclk;
  program_status_flags i_program_status_flags (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .alu_update,
    .upd_carry, .upd_aux_carry, .upd_overflow, .alu_carry_out,
    .alu_carry_bit6, .alu_nibble_carry, .bit_write, .bit_value,
    .accumulator, .status_word, .carry_flag, .bank_base);
  alu_sequencer_model i_alu_sequencer_model (.aclk, .alu_update, .upd_carry,
    .upd_aux_carry, .upd_overflow, .alu_carry_out, .alu_carry_bit6,
    .alu_nibble_carry, .bit_write, .bit_value, .accumulator);
  // Compare, verdict and bus cycles
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic st(input logic [7:0] e, input logic [7:0] b);
    #1;
    chk({24'h0, status_word}, {24'h0, e});
    chk({24'h0, bank_base}, {24'h0, b});
    chk({31'h0, carry_flag}, {31'h0, e[7]});
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Scenarios
  task automatic t_bank;
    for (int b = 0; b < 4; b++) begin
      wr(REG_ADDR, {3'h1, 2'(b), 3'h3}, 4'hf, flags_pkg::RESP_OKAY);
      st({3'h1, 2'(b), 3'h2}, {3'h0, 2'(b), 3'h0});
      rd(REG_ADDR, {27'h1, 2'(b), 3'h2}, flags_pkg::RESP_OKAY);
    end
  endtask
  task automatic t_arith;
    wr(REG_ADDR, 8'h22, 4'hf, flags_pkg::RESP_OKAY);
    i_alu_sequencer_model.arith(3'h7, 3'h5);
    st(8'he6, 8'h00);
    i_alu_sequencer_model.arith(3'h7, 3'h7);
    st(8'he2, 8'h00);
    i_alu_sequencer_model.arith(3'h1, 3'h4);
    st(8'he6, 8'h00);
    i_alu_sequencer_model.arith(3'h6, 3'h0);
    st(8'h26, 8'h00);
  endtask
  task automatic t_bit_parity;
    i_alu_sequencer_model.bitop(1'h1);
    st(8'ha6, 8'h00);
    i_alu_sequencer_model.bitop(1'h0);
    st(8'h26, 8'h00);
    i_alu_sequencer_model.load(8'h07);
    @(posedge aclk);
    st(8'h27, 8'h00);
    rd(REG_ADDR, 32'h27, flags_pkg::RESP_OKAY);
    i_alu_sequencer_model.load(8'h03);
    @(posedge aclk);
    st(8'h26, 8'h00);
  endtask
  // Lane 0 disabled leaves the word alone; unmapped place answers error
  task automatic t_strobe_unmapped;
    wr(REG_ADDR, 8'hfe, 4'he, flags_pkg::RESP_OKAY);
    st(8'h26, 8'h00);
    rd(12'h0d4, 32'h0, flags_pkg::RESP_SLVERR);
    wr(12'h0d4, 8'hff, 4'hf, flags_pkg::RESP_SLVERR);
    st(8'h26, 8'h00);
  endtask
  // Reset in mid-run clears the word; parity returns one edge later
  task automatic t_reset;
    wr(REG_ADDR, 8'hff, 4'hf, flags_pkg::RESP_OKAY);
    st(8'hfe, 8'h18);
    i_alu_sequencer_model.load(8'h01);
    @(posedge aclk);
    st(8'hff, 8'h18);
    @(posedge aclk);
    aresetn <= 1'h0;
    @(posedge aclk);
    st(8'h00, 8'h00);
    @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    st(8'h01, 8'h00);
    rd(REG_ADDR, 32'h01, flags_pkg::RESP_OKAY);
  endtask
  // Main sequence: reset, then the scenarios
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    st(8'h00, 8'h00);
    t_bank();
    t_arith();
    t_bit_parity();
    t_strobe_unmapped();
    t_reset();
    final_report();
  end
  // Watchdog against a hung handshake
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
